/* shared/pesd_map.vh */
// pesd_map.vh: register map, field layout and event codes of the
// performance event selector.
// assumes: included by the selector and its checker; byte addresses, 32-bit words.
`ifndef PESD_MAP_VH
`define PESD_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PESD_OFF_CTRL 8'h00
`define PESD_OFF_COUNT 8'h04
`define PESD_OFF_BYTES 8'h08
`define PESD_OFF_STATUS 8'h0C

// ----------------------------------------
// control fields
// ----------------------------------------
`define PESD_CTRL_CODE_LSB 0
`define PESD_CTRL_CODE_MSB 7
`define PESD_CTRL_MASK_LSB 8
`define PESD_CTRL_MASK_MSB 15
`define PESD_CTRL_GRAN32_BIT 16
`define PESD_CTRL_RESET 32'h0000_0000

// ----------------------------------------
// status fields
// ----------------------------------------
`define PESD_STAT_GRAN32_BIT 0
`define PESD_STAT_OVERHEAD_BIT 1

// ----------------------------------------
// event codes
// ----------------------------------------
`define PESD_EV_INT_TAKEN 8'hCF
`define PESD_EV_DEC_EMPTY 8'hD0
`define PESD_EV_STALL_ANY 8'hD1
`define PESD_EV_STALL_FIRST 8'hD2
`define PESD_EV_STALL_LAST 8'hDA
`define PESD_EV_FPU_EXC 8'hDB
`define PESD_EV_BKPT_FIRST 8'hDC
`define PESD_EV_BKPT_LAST 8'hDF
`define PESD_EV_DRAM_ACC 8'hE0
`define PESD_EV_PAGE_TBL 8'hE1
`define PESD_EV_TURNAROUND 8'hE3

// ----------------------------------------
// qualifier masks with reserved bits removed
// ----------------------------------------
`define PESD_QM_FPU_VALID 8'h0F
`define PESD_QM_DRAM_VALID 8'hFF
`define PESD_QM_PTBL_VALID 8'h0F
`define PESD_QM_TURN_VALID 8'h3F

// ----------------------------------------
// timing and block sizes
// ----------------------------------------
`define PESD_BKPT_OVERHEAD_CYC 120
`define PESD_BLOCK_BYTES_64 8'h40
`define PESD_BLOCK_BYTES_32 8'h20

`endif

/* hdl/pesd_event_selector.v */
// pesd_event_selector.v: event selection and counting for core
// interrupt, dispatch, debug and dram controller events.
// assumes: all event strobes come from logic on clk, one bit per
// occurrence per cycle; software on the plain register port.

`timescale 1ns/1ps
`default_nettype none

`include "pesd_map.vh"

module pesd_event_selector
#(
    parameter CNT_W = 32,
    parameter ADDR_W = 8
)
(
    input wire clk,
    input wire resetn,
    input wire [ADDR_W-1:0] regAddr,
    input wire [31:0] regWdata,
    input wire regWrite,
    input wire regRead,
    output reg [31:0] regRdata,
    input wire hwIntTaken,
    input wire decoderEmpty,
    input wire [8:0] stallCause,
    input wire [3:0] fpuException,
    input wire [3:0] bkptMatch,
    input wire [3:0] bkptIsInstr,
    input wire [2:0] chanZeroPage,
    input wire [2:0] chanOnePage,
    input wire dramWriteReq,
    input wire dramReadReq,
    input wire dualChannel,
    input wire newPageReq,
    input wire pageTableFull,
    input wire staleEntryHit,
    input wire idleLimitInc,
    input wire idleLimitDec,
    input wire [5:0] turnaround,
    output reg closeOldestPage,
    output reg bkptOverheadStall,
    output wire [CNT_W-1:0] eventCount
);

// ----------------------------------------
// helpers
// ----------------------------------------
function [3:0] popCount8;
    input [7:0] v;
    integer i;
    begin
        popCount8 = 4'h0;
        for (i = 0; i < 8; i = i + 1)
        begin
            popCount8 = popCount8 + {3'b000, v[i]};
        end
    end
endfunction

function regHit;
    input [ADDR_W-1:0] a;
    input [7:0] off;
    begin
        regHit = (a == off[ADDR_W-1:0]);
    end
endfunction

// ----------------------------------------
// software registers
// ----------------------------------------
// control fields held as written; status shows the effective view
reg [7:0] eventCodeSelect;
reg [7:0] eventQualifierMask;
reg gran32Req;
reg [CNT_W-1:0] count;
reg [31:0] dramBytes;
reg [6:0] overheadLeft;

wire gran32Eff;
// 32-byte blocks only make sense with one channel populated
assign gran32Eff = gran32Req & ~dualChannel;

wire wrCtrl;
wire wrCount;
wire wrBytes;
assign wrCtrl = regWrite & regHit(regAddr, `PESD_OFF_CTRL);
assign wrCount = regWrite & regHit(regAddr, `PESD_OFF_COUNT);
assign wrBytes = regWrite & regHit(regAddr, `PESD_OFF_BYTES);

always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        eventCodeSelect <= 8'h00;
        eventQualifierMask <= 8'h00;
        gran32Req <= 1'b0;
    end
    else if (wrCtrl)
    begin
        eventCodeSelect <= regWdata[`PESD_CTRL_CODE_MSB:`PESD_CTRL_CODE_LSB];
        eventQualifierMask <= regWdata[`PESD_CTRL_MASK_MSB:`PESD_CTRL_MASK_LSB];
        gran32Req <= regWdata[`PESD_CTRL_GRAN32_BIT];
    end
end

// ----------------------------------------
// page table overflow
// ----------------------------------------
wire pageOverflow;
// table full is a level, the new page request a pulse
assign pageOverflow = newPageReq & pageTableFull;

always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        closeOldestPage <= 1'b0;
    end
    else
    begin
        // oldest entry closed speculatively, one cycle pulse
        closeOldestPage <= pageOverflow;
    end
end

// ----------------------------------------
// breakpoint overhead
// ----------------------------------------
wire instrBkptHit;
assign instrBkptHit = |(bkptMatch & bkptIsInstr);
// data breakpoint matches leave the pipe alone

always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        overheadLeft <= 7'h00;
        bkptOverheadStall <= 1'b0;
    end
    else if (instrBkptHit)
    begin
        // a new match restarts the penalty window
        overheadLeft <= 7'd`PESD_BKPT_OVERHEAD_CYC - 7'd1;
        bkptOverheadStall <= 1'b1;
    end
    else if (overheadLeft != 7'h00)
    begin
        overheadLeft <= overheadLeft - 7'd1;
        bkptOverheadStall <= 1'b1;
    end
    else
    begin
        bkptOverheadStall <= 1'b0;
    end
end

// ----------------------------------------
// condition vectors
// ----------------------------------------
wire [7:0] dramVec;
wire [7:0] ptblVec;
wire [7:0] turnVec;
wire [7:0] fpuVec;
assign dramVec = {dramReadReq, dramWriteReq, chanOnePage, chanZeroPage};
assign ptblVec = {4'h0, idleLimitDec, idleLimitInc, staleEntryHit, pageOverflow};
assign turnVec = {2'b00, turnaround};
assign fpuVec = {4'h0, fpuException};

// code minus base gives the cause bit or breakpoint number
wire [7:0] stallIdx;
wire [7:0] bkptIdx;
assign stallIdx = eventCodeSelect - `PESD_EV_STALL_FIRST;
assign bkptIdx = eventCodeSelect - `PESD_EV_BKPT_FIRST;

// ----------------------------------------
// increment selection
// ----------------------------------------
// codes outside the decoded set, e2h included, count nothing
reg [3:0] next_inc;
reg dramSel;

always @*
begin
    next_inc = 4'h0;
    dramSel = 1'b0;
    case (eventCodeSelect)
        `PESD_EV_INT_TAKEN:
        begin
            // software interrupt instructions never reach this strobe
            next_inc = {3'b000, hwIntTaken};
        end
        `PESD_EV_DEC_EMPTY:
        begin
            next_inc = {3'b000, decoderEmpty};
        end
        `PESD_EV_STALL_ANY:
        begin
            // overlap of causes still adds one per cycle
            next_inc = {3'b000, |stallCause};
        end
        `PESD_EV_FPU_EXC:
        begin
            next_inc = popCount8(fpuVec & eventQualifierMask
                & `PESD_QM_FPU_VALID);
        end
        `PESD_EV_DRAM_ACC:
        begin
            next_inc = popCount8(dramVec & eventQualifierMask
                & `PESD_QM_DRAM_VALID);
            dramSel = 1'b1;
        end
        `PESD_EV_PAGE_TBL:
        begin
            next_inc = popCount8(ptblVec & eventQualifierMask
                & `PESD_QM_PTBL_VALID);
        end
        `PESD_EV_TURNAROUND:
        begin
            next_inc = popCount8(turnVec & eventQualifierMask
                & `PESD_QM_TURN_VALID);
        end
        default:
        begin
            if (eventCodeSelect >= `PESD_EV_STALL_FIRST
                && eventCodeSelect <= `PESD_EV_STALL_LAST)
            begin
                // one cause per code; far transfer drain never overlaps
                next_inc = {3'b000, stallCause[stallIdx[3:0]]};
            end
            else if (eventCodeSelect >= `PESD_EV_BKPT_FIRST
                && eventCodeSelect <= `PESD_EV_BKPT_LAST)
            begin
                // match counted whether or not the breakpoint is enabled
                next_inc = {3'b000, bkptMatch[bkptIdx[1:0]]};
            end
            else
            begin
                next_inc = 4'h0;
            end
        end
    endcase
end

// ----------------------------------------
// counters
// ----------------------------------------
// increment is at most eight per cycle, so four bits suffice
wire [7:0] blockBytes;
assign blockBytes = gran32Eff ? `PESD_BLOCK_BYTES_32 : `PESD_BLOCK_BYTES_64;

wire [3:0] pageBlocks;
wire [31:0] dramAdd;
// only page outcomes are real data blocks; request type bits tag them
assign pageBlocks = popCount8({2'b00, dramVec[5:0] & eventQualifierMask[5:0]});
// six blocks at most per cycle, so the 32-bit product never wraps
assign dramAdd = dramSel
    ? ({24'h00_0000, blockBytes} * {28'h000_0000, pageBlocks})
    : 32'h0000_0000;

always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        count <= {CNT_W{1'b0}};
    end
    else if (wrCount)
    begin
        // software write loads, an event that cycle is dropped
        count <= regWdata[CNT_W-1:0];
    end
    else
    begin
        count <= count + {{(CNT_W-4){1'b0}}, next_inc};
    end
end

always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        dramBytes <= 32'h0000_0000;
    end
    else if (wrBytes)
    begin
        dramBytes <= regWdata;
    end
    else
    begin
        dramBytes <= dramBytes + dramAdd;
    end
end

assign eventCount = count;

// ----------------------------------------
// read port
// ----------------------------------------
reg [31:0] next_rdata;
// unmapped offsets read zero; writes to them are dropped

always @*
begin
    next_rdata = 32'h0000_0000;
    if (regHit(regAddr, `PESD_OFF_CTRL))
    begin
        next_rdata[`PESD_CTRL_CODE_MSB:`PESD_CTRL_CODE_LSB] = eventCodeSelect;
        next_rdata[`PESD_CTRL_MASK_MSB:`PESD_CTRL_MASK_LSB] = eventQualifierMask;
        next_rdata[`PESD_CTRL_GRAN32_BIT] = gran32Req;
    end
    else if (regHit(regAddr, `PESD_OFF_COUNT))
    begin
        next_rdata = count[31:0];
    end
    else if (regHit(regAddr, `PESD_OFF_BYTES))
    begin
        next_rdata = dramBytes;
    end
    else if (regHit(regAddr, `PESD_OFF_STATUS))
    begin
        next_rdata[`PESD_STAT_GRAN32_BIT] = gran32Eff;
        next_rdata[`PESD_STAT_OVERHEAD_BIT] = bkptOverheadStall;
    end
    else
    begin
        next_rdata = 32'h0000_0000;
    end
end

always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        regRdata <= 32'h0000_0000;
    end
    else if (regRead)
    begin
        regRdata <= next_rdata;
    end
    else
    begin
        // data stands only in the cycle after the strobe
        regRdata <= 32'h0000_0000;
    end
end

endmodule

`default_nettype wire

/* dv/pesd_event_src.sv */
// pesd_event_src.sv: model of the core pipeline and dram controller
// event sources feeding the selector.
// assumes: one clock; bench commands a burst with fire, one cycle long.
`timescale 1ns/1ps
`default_nettype none

module pesd_event_src
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic fire,
    input wire logic [42:0] evCmd,
    output logic [42:0] evOut
);
    // page table full, dual channel and breakpoint types are levels;
    // every other bit is a one-cycle strobe, one bit per occurrence
    localparam logic [42:0] LEVELS = 43'h000_00F0_0A00;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            evOut <= '0;
        else if (fire)
            evOut <= evCmd;
        else
            evOut <= evOut & LEVELS;
    end
endmodule
`default_nettype wire

/* dv/pesd_event_selector_checker.sv */
// pesd_event_selector_checker.sv: assertions on the selector's ports.
// assumes: bound into every selector instance; control shadowed from writes.
`timescale 1ns/1ps
`default_nettype none
`include "pesd_map.vh"

module pesd_event_selector_checker
#(
    parameter CNT_W = 32,
    parameter ADDR_W = 8
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    input wire logic hwIntTaken,
    input wire logic [8:0] stallCause,
    input wire logic [3:0] fpuException,
    input wire logic [3:0] bkptMatch,
    input wire logic [3:0] bkptIsInstr,
    input wire logic newPageReq,
    input wire logic pageTableFull,
    input wire logic closeOldestPage,
    input wire logic bkptOverheadStall,
    input wire logic [CNT_W-1:0] eventCount
);
    logic [7:0] shCode;
    logic [7:0] shMask;
    logic [7:0] ovCnt;
    wire logic cntWr;
    wire logic instrHit;
    assign cntWr = regWrite && regAddr == `PESD_OFF_COUNT;
    assign instrHit = |(bkptMatch & bkptIsInstr);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            shCode <= 8'h00;
            shMask <= 8'h00;
        end
        else if (regWrite && regAddr == `PESD_OFF_CTRL)
        begin
            shCode <= regWdata[7:0];
            shMask <= regWdata[15:8];
        end
    end

    // overhead window: rematch restarts it, 8'h78 is the last stall cycle
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ovCnt <= 8'h00;
        else if (instrHit)
            ovCnt <= 8'h01;
        else if (ovCnt == 8'h78 || ovCnt == 8'h00)
            ovCnt <= 8'h00;
        else
            ovCnt <= ovCnt + 8'h01;
    end

    sequence s_overflow;
        newPageReq && pageTableFull;
    endsequence

    a_read_idle: assert property (!regRead |=> regRdata == 32'h0000_0000)
        else $error("read data not zero outside answer cycle");
    a_count_load: assert property (cntWr |=> eventCount == CNT_W'($past(regWdata)))
        else $error("count write not loaded");
    a_int_count: assert property (
        shCode == `PESD_EV_INT_TAKEN && !cntWr
        |=> eventCount == $past(eventCount) + CNT_W'($past(hwIntTaken)))
        else $error("interrupt count wrong");
    a_stall_any: assert property (
        shCode == `PESD_EV_STALL_ANY && !cntWr
        |=> eventCount == $past(eventCount) + CNT_W'(|$past(stallCause)))
        else $error("net stall count wrong");
    a_fpu_sum: assert property (
        shCode == `PESD_EV_FPU_EXC && !cntWr
        |=> eventCount == $past(eventCount)
            + CNT_W'($countones({4'h0, $past(fpuException)} & $past(shMask))))
        else $error("fpu exception count wrong");
    a_turn_reserved: assert property (
        shCode == `PESD_EV_TURNAROUND && (shMask & 8'h3F) == 8'h00 && !cntWr
        |=> $stable(eventCount))
        else $error("reserved qualifier counted");
    a_close_pulse: assert property (s_overflow |=> closeOldestPage)
        else $error("overflow did not close oldest page");
    a_close_only: assert property (
        !(newPageReq && pageTableFull) |=> !closeOldestPage)
        else $error("page closed without overflow");
    a_overhead_len: assert property (bkptOverheadStall == (ovCnt != 8'h00))
        else $error("overhead stall window wrong");
endmodule

bind pesd_event_selector pesd_event_selector_checker #(.CNT_W(CNT_W), .ADDR_W(ADDR_W)) chk (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .hwIntTaken(hwIntTaken), .stallCause(stallCause), .fpuException(fpuException),
    .bkptMatch(bkptMatch), .bkptIsInstr(bkptIsInstr), .newPageReq(newPageReq),
    .pageTableFull(pageTableFull), .closeOldestPage(closeOldestPage),
    .bkptOverheadStall(bkptOverheadStall), .eventCount(eventCount));
`default_nettype wire

/* dv/pesd_event_selector_tb.sv */
// pesd_event_selector_tb.sv: self-checking bench for the event selector.
// assumes: event source model drives all event inputs; bench is bus master.
`timescale 1ns/1ps
`default_nettype none

module pesd_event_selector_tb;
    typedef struct packed {logic [15:0] ctrl; logic [42:0] ev; logic [31:0] exp;} pesd_row_t;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0000_0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic fire = 1'b0;
    logic [42:0] evCmd = '0;
    wire logic [42:0] evOut;
    wire logic [31:0] regRdata;
    wire logic [31:0] eventCount;
    wire logic closeOldestPage;
    wire logic bkptOverheadStall;
    int errorCnt = 0;
    int checksDone = 0;
    int n;
    pesd_row_t rows [23];

    always #2.5 clk = ~clk;

    pesd_event_src src (.clk(clk), .resetn(resetn), .fire(fire), .evCmd(evCmd), .evOut(evOut));

    pesd_event_selector dut (
        .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .hwIntTaken(evOut[42]), .decoderEmpty(evOut[41]), .stallCause(evOut[40:32]),
        .fpuException(evOut[31:28]), .bkptMatch(evOut[27:24]), .bkptIsInstr(evOut[23:20]),
        .chanZeroPage(evOut[19:17]), .chanOnePage(evOut[16:14]), .dramWriteReq(evOut[13]),
        .dramReadReq(evOut[12]), .dualChannel(evOut[11]), .newPageReq(evOut[10]),
        .pageTableFull(evOut[9]), .staleEntryHit(evOut[8]), .idleLimitInc(evOut[7]),
        .idleLimitDec(evOut[6]), .turnaround(evOut[5:0]), .closeOldestPage(closeOldestPage),
        .bkptOverheadStall(bkptOverheadStall), .eventCount(eventCount));

    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            errorCnt++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk(regRdata, exp);
    endtask

    task automatic pulse(input logic [42:0] ev);
        @(posedge clk);
        evCmd <= ev;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask

    task automatic stallLen(input logic [42:0] ev, input logic [31:0] exp);
        pulse(ev);
        n = 0;
        repeat (200)
        begin
            @(posedge clk);
            #1 if (bkptOverheadStall === 1'b1) n++;
        end
        chk(32'(n), exp);
    endtask

    task automatic printVerdict;
        $display("checks %0d errors %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        rows[0] = '{16'h00CF, 43'h400_0000_0000, 32'h0000_0001};
        rows[1] = '{16'h00D0, 43'h200_0000_0000, 32'h0000_0001};
        rows[2] = '{16'h00D1, 43'h1FF_0000_0000, 32'h0000_0001};
        rows[3] = '{16'hFFDB, 43'h000_F000_0000, 32'h0000_0004};
        rows[4] = '{16'hF0DB, 43'h000_F000_0000, 32'h0000_0000};
        rows[5] = '{16'hFFE0, 43'h000_000F_F000, 32'h0000_0008};
        rows[6] = '{16'hFFE1, 43'h000_0000_07C0, 32'h0000_0004};
        rows[7] = '{16'hF0E1, 43'h000_0000_07C0, 32'h0000_0000};
        rows[8] = '{16'hFFE3, 43'h000_0000_003F, 32'h0000_0006};
        rows[9] = '{16'hC0E3, 43'h000_0000_003F, 32'h0000_0000};
        for (n = 0; n < 9; n++)
            rows[10+n] = '{16'h00D2 + 16'(n), 43'h1 << (32 + n),
                32'h0000_0001};
        for (n = 0; n < 4; n++)
            rows[19+n] = '{16'h00DC + 16'(n), 43'h1 << (24 + n), 32'h0000_0001};
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rd(8'h04, 32'h0000_0000);
        rd(8'h00, 32'h0000_0000);
        rd(8'h0C, 32'h0000_0000);
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10, 32'h0000_0000);
        foreach (rows[i])
        begin
            wr(8'h00, {16'h0000, rows[i].ctrl});
            wr(8'h04, 32'h0000_0000);
            pulse(rows[i].ev);
            rd(8'h04, rows[i].exp);
        end
        // single channel may run 32-byte blocks
        wr(8'h00, 32'h0001_03E0);
        wr(8'h08, 32'h0000_0000);
        pulse(43'h000_0006_0000);
        rd(8'h08, 32'h0000_0040);
        rd(8'h0C, 32'h0000_0001);
        // dual channel overrides the request back to 64-byte
        wr(8'h08, 32'h0000_0000);
        pulse(43'h000_0006_0800);
        rd(8'h08, 32'h0000_0080);
        rd(8'h0C, 32'h0000_0000);
        stallLen(43'h000_0110_0000, 32'h0000_0078);
        stallLen(43'h000_0200_0000, 32'h0000_0000);
        rd(8'h04, 32'h0000_0005);
        // reset in mid-run clears count and control
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(8'h04, 32'h0000_0000);
        rd(8'h00, 32'h0000_0000);
        // undecoded code e2h counts nothing
        wr(8'h00, 32'h0000_FFE2);
        wr(8'h04, 32'h0000_0000);
        pulse(43'h7FF_F00F_FFFF);
        rd(8'h04, 32'h0000_0000);
        printVerdict();
    end
endmodule
`default_nettype wire
